// file: shared/rheo_defs.svh
// Constants for the rheostat serial command logic: command codes,
// reset values, fuse store timing and link bit positions.
// Assumes inclusion by bare name from the package and the design files.
`ifndef RHEO_DEFS_SVH
`define RHEO_DEFS_SVH
// Command codes of the four-bit command field
`define RHEO_CMD_NOP 4'h0
`define RHEO_CMD_WIPER 4'h1
`define RHEO_CMD_RD_WIPER 4'h2
`define RHEO_CMD_STORE 4'h3
`define RHEO_CMD_RESTORE 4'h4
`define RHEO_CMD_RD_ADDR 4'h6
`define RHEO_CMD_CTRL 4'h7
`define RHEO_CMD_RD_CTRL 4'h8
// Reset, blank-fuse and last-fuse values
`define RHEO_MIDSCALE 10'h0200
`define RHEO_CTRL_RESET 4'h0
`define RHEO_FILL_BLANK 6'h00
`define RHEO_OTP_LAST 6'h32
// Fuse store time, clock rate, and derived cycle count
`define RHEO_STORE_MS 350
`define RHEO_CLK_HZ 20000000
`define RHEO_STORE_CYC (`RHEO_STORE_MS * (`RHEO_CLK_HZ / 1000))
// Bit counter value of the sixteenth bit of a word
`define RHEO_LAST_BIT 4'hF
`endif

// file: shared/rheo_pkg.sv
// Types shared by the rheostat command logic and its link front end.
// Assumes the constants header is on the include path.
`include "rheo_defs.svh"
package rheo_pkg;
  // One sixteen-bit serial word, top bits first
  typedef struct packed {
    logic [1:0] unused;
    logic [3:0] cmd;
    logic [9:0] data;
  } frame_t;
  // Control register, program enable in bit zero
  typedef struct packed {
    logic store_success_flag;
    logic tolerance_cal_disable;
    logic wiper_write_unlock;
    logic program_enable_bit;
  } ctrl_t;
  // Gray codes along restore, fetch, idle, store
  typedef enum logic [1:0] {
    ST_RESTORE = 2'h0,
    ST_FETCH = 2'h1,
    ST_IDLE = 2'h3,
    ST_STORE = 2'h2
  } state_t;
endpackage : rheo_pkg

// file: design/rheo_serial_link.sv
// Link front end on the serial clock: shift register, bit counter,
// word hand-off toggle and open-drain readback enable.
// Assumes the serial clock only moves while frame select is low.
`timescale 1ns/1ps
`include "rheo_defs.svh"
module rheo_serial_link
  import rheo_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic din,
  input wire logic rb_en,
  input wire logic [15:0] rb_word,
  output frame_t word_r,
  output logic word_tgl_r,
  output logic sdo_oe_r
);
  // Bit position within the current word
  logic [3:0] bit_cnt_r;
  // First fifteen bits of the word being loaded
  logic [14:0] shift_r;
  // Frame select high clears the counter, since no clock edge follows
  wire logic link_clr = ~rst_n | sync_n;
  wire logic last_bit = (bit_cnt_r == `RHEO_LAST_BIT);
  wire logic [15:0] frame_w = {shift_r, din};

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 15'h0000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= frame_w[14:0];
    end
  end

  // every sixteenth bit completes
  // Word stays stable for a whole word time after the toggle
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= frame_t'(16'h0000);
      word_tgl_r <= 1'b0;
    end else if (last_bit) begin
      word_r <= frame_t'(frame_w);
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // Readback bits change on the rising edge, host samples on falling.
  // rb_en and rb_word are quasi-static: they change only after a frame.
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= rb_en & ~rb_word[~bit_cnt_r];
    end
  end
endmodule : rheo_serial_link

// file: design/rheo_otp_mem.sv
// One-time wiper store: fifty fuse words and the fill pointer.
// Assumes the caller never writes once the store is full.
`timescale 1ns/1ps
`include "rheo_defs.svh"
module rheo_otp_mem
  import rheo_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [9:0] wdata,
  output logic [9:0] rdata_r,
  output logic [5:0] fill_r
);
  // Fuse array, location zero is reserved
  logic [9:0] mem_r [0:63];
  // Fuse state survives logic reset, so it starts blank only once
  logic [5:0] ptr_r = `RHEO_FILL_BLANK;
  // Pointer flop is the only writer of the fill output
  assign fill_r = ptr_r;

  // Program next location and advance the pointer
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[ptr_r + 6'h01] <= wdata;
      ptr_r <= ptr_r + 6'h01;
    end
  end

  // Registered read of the last programmed location
  always_ff @(posedge clk) begin
    rdata_r <= mem_r[ptr_r];
  end
endmodule : rheo_otp_mem

// file: design/rheostat_serial_command_logic.sv
// Serial command logic of a single-channel digital rheostat:
// frame crossing, command decode, wiper and control registers,
// fuse store sequencing and power-up restore.
// Assumes an SPI master drives sync_n, sclk and din, and an external
// pull-up on the open-drain readback pin.
// Function
// - Sixteen-bit word: two spare, command, data
// - Bits travel top bit first
// - Command field picks target, data supplies value
// - Coarse variant drops two lowest data bits
// - Execute only when frame select rises
// - Frames are whole multiples of sixteen bits
// - Serial clock may stop between frames
// - Program enable defaults off, blocks stores
// - Write unlock gates wiper updates
// - Calibration disable bit, default calibrated
// - Success flag set when store completes
// - Locked wiper holds stored or midscale
// - Code one loads wiper, zero idles
// - Code two arms wiper readback
// - Code three stores wiper into fuses
// - Store lasts 350 ms, refuses changes
// - Wiper rewrites are unlimited
// - Reset reloads wiper from last store
// - Data sampled on falling clock edge
// - Short frame aborts, registers unchanged
// - Code seven writes three control bits
`timescale 1ns/1ps
`include "rheo_defs.svh"
module rheostat_serial_command_logic
  import rheo_pkg::*;
#(
  parameter int STORE_CYCLES = `RHEO_STORE_CYC,
  parameter bit COARSE = 1'b0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic [9:0] wiper_position,
  output logic tolerance_cal_disable,
  output logic store_success_flag,
  output logic otp_busy
);
  // Frame select synchroniser plus one lag stage and one edge stage
  logic [3:0] sync_sr_r;
  // Word toggle synchroniser plus edge stage
  logic [2:0] tgl_sr_r;
  // Word handed over from the link domain
  frame_t link_word;
  logic link_tgl;
  logic link_oe;
  // Latest complete word of the current frame
  frame_t cap_r;
  logic pend_r;
  // Machine, registers and readback state
  state_t state_r;
  state_t state_nxt;
  ctrl_t ctrl_r;
  ctrl_t ctrl_nxt;
  logic [9:0] wiper_r;
  logic [9:0] wiper_nxt;
  logic [22:0] wait_r;
  logic busy_r;
  logic rb_en_r;
  logic [15:0] rb_word_r;
  logic [15:0] rb_word_nxt;
  // Fuse store ports
  logic [9:0] otp_rdata;
  logic [5:0] otp_fill;
  // Link domain front end
  rheo_serial_link u_link (
    .sclk(sclk),
    .rst_n(rst_n),
    .sync_n(sync_n),
    .din(din),
    .rb_en(rb_en_r),
    .rb_word(rb_word_r),
    .word_r(link_word),
    .word_tgl_r(link_tgl),
    .sdo_oe_r(link_oe)
  );

  // Crossing edges; frame select lags the toggle by one stage so
  // the last word is seen before the frame end is acted on
  wire logic frame_rise = sync_sr_r[2] & ~sync_sr_r[3];
  wire logic frame_fall = ~sync_sr_r[2] & sync_sr_r[3];
  wire logic word_seen = tgl_sr_r[1] ^ tgl_sr_r[2];
  wire logic exec_w = frame_rise & pend_r;
  wire logic idle_w = (state_r == ST_IDLE);
  wire logic cmd_ok = exec_w & idle_w;
  wire logic [3:0] cmd_w = cap_r.cmd;
  wire logic do_wiper = cmd_ok & (cmd_w == `RHEO_CMD_WIPER);
  wire logic do_rd_wiper = cmd_ok & (cmd_w == `RHEO_CMD_RD_WIPER);
  wire logic do_store = cmd_ok & (cmd_w == `RHEO_CMD_STORE);
  wire logic do_restore = cmd_ok & (cmd_w == `RHEO_CMD_RESTORE);
  wire logic do_rd_addr = cmd_ok & (cmd_w == `RHEO_CMD_RD_ADDR);
  wire logic do_ctrl = cmd_ok & (cmd_w == `RHEO_CMD_CTRL);
  wire logic do_rd_ctrl = cmd_ok & (cmd_w == `RHEO_CMD_RD_CTRL);
  wire logic do_read = do_rd_wiper | do_rd_addr | do_rd_ctrl;
  wire logic wiper_ok = do_wiper & ctrl_r.wiper_write_unlock;
  wire logic store_go = do_store & ctrl_r.program_enable_bit;
  wire logic [9:0] wiper_data = COARSE ? {cap_r.data[9:2], 2'b00} : cap_r.data;
  wire logic otp_full = (otp_fill == `RHEO_OTP_LAST);
  wire logic fill_blank = (otp_fill == `RHEO_FILL_BLANK);
  wire logic store_done = (state_r == ST_STORE) & (wait_r == 23'h00_0000);
  wire logic otp_we = store_done & ~otp_full;

  // Fuse store with registered read of the last location
  rheo_otp_mem u_otp (
    .clk(clk),
    .we(otp_we),
    .wdata(wiper_r),
    .rdata_r(otp_rdata),
    .fill_r(otp_fill)
  );

  // Two flip-flops per crossing signal before any logic
  // no serial clock needed here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_sr_r <= 4'hF;
      tgl_sr_r <= 3'h0;
    end else begin
      sync_sr_r <= {sync_sr_r[2:0], sync_n};
      tgl_sr_r <= {tgl_sr_r[1:0], link_tgl};
    end
  end

  // last word of long frame wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_r <= frame_t'(16'h0000);
      pend_r <= 1'b0;
    end else begin
      if (word_seen) begin
        cap_r <= link_word;
      end
      // A new word wins over the frame edge clear
      pend_r <= word_seen | (pend_r & ~frame_fall & ~frame_rise);
    end
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RESTORE: begin
        // Blank fuses need no read
        state_nxt = fill_blank ? ST_IDLE : ST_FETCH;
      end
      ST_FETCH: begin
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (store_go) begin
          state_nxt = ST_STORE;
        end else if (do_restore) begin
          state_nxt = ST_RESTORE;
        end
      end
      ST_STORE: begin
        if (store_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_RESTORE;
      end
    endcase
  end

  assign wiper_nxt = (state_r == ST_FETCH) ? otp_rdata :
                     (state_r == ST_RESTORE && fill_blank) ? `RHEO_MIDSCALE :
                     wiper_ok ? wiper_data : wiper_r;

  assign ctrl_nxt.program_enable_bit = do_ctrl ? cap_r.data[0] : ctrl_r.program_enable_bit;
  assign ctrl_nxt.wiper_write_unlock = do_ctrl ? cap_r.data[1] : ctrl_r.wiper_write_unlock;
  assign ctrl_nxt.tolerance_cal_disable =
    do_ctrl ? cap_r.data[2] : ctrl_r.tolerance_cal_disable;
  assign ctrl_nxt.store_success_flag = store_done ? ~otp_full :
                                       do_store ? 1'b0 : ctrl_r.store_success_flag;

  assign rb_word_nxt = do_rd_wiper ? {6'h00, wiper_r} :
                       do_rd_addr ? {10'h000, otp_fill} :
                       do_rd_ctrl ? {12'h000, ctrl_r} : rb_word_r;

  // Machine and registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_RESTORE;
      ctrl_r <= ctrl_t'(`RHEO_CTRL_RESET);
      wiper_r <= `RHEO_MIDSCALE;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      wiper_r <= wiper_nxt;
      busy_r <= (state_nxt == ST_STORE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_r <= 23'h00_0000;
    end else if (store_go) begin
      wait_r <= 23'(STORE_CYCLES - 1);
    end else if (wait_r != 23'h00_0000) begin
      wait_r <= wait_r - 23'h00_0001;
    end
  end

  // Readback is armed for the next frame only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rb_en_r <= 1'b0;
      rb_word_r <= 16'h0000;
    end else begin
      if (frame_rise) begin
        rb_en_r <= do_read;
      end
      rb_word_r <= rb_word_nxt;
    end
  end

  // Outputs; the pin itself only ever pulls low
  assign serial_data_out = 1'b0;
  assign serial_data_out_oe = link_oe;
  assign wiper_position = wiper_r;
  assign tolerance_cal_disable = ctrl_r.tolerance_cal_disable;
  assign store_success_flag = ctrl_r.store_success_flag;
  assign otp_busy = busy_r;

  // Checks on the system clock
  default clocking cb_sys @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_store_start;
    idle_w && exec_w && (cmd_w == `RHEO_CMD_STORE) && ctrl_r.program_enable_bit;
  endsequence

  sequence s_locked_write;
    idle_w && exec_w && (cmd_w == `RHEO_CMD_WIPER) && !ctrl_r.wiper_write_unlock;
  endsequence

  a_store_busy_hold: assert property (s_store_start |=> busy_r [*8])
    else $error("store did not hold busy");

  a_locked_write_drop: assert property (s_locked_write |=> $stable(wiper_r))
    else $error("locked wiper write changed wiper");

  a_wiper_write_load: assert property (
    (idle_w && exec_w && (cmd_w == `RHEO_CMD_WIPER) && ctrl_r.wiper_write_unlock)
    |=> (wiper_r == $past(wiper_data)))
    else $error("unlocked wiper write not loaded");

  a_ctrl_write_bits: assert property (
    (idle_w && exec_w && (cmd_w == `RHEO_CMD_CTRL))
    |=> (ctrl_r[2:0] == $past(cap_r.data[2:0])))
    else $error("control write not applied");

  a_store_disabled: assert property (
    (idle_w && exec_w && (cmd_w == `RHEO_CMD_STORE) && !ctrl_r.program_enable_bit)
    |=> (!busy_r && !ctrl_r.store_success_flag))
    else $error("disabled store acted");

  a_abort_no_change: assert property (
    (frame_rise && !pend_r) |=> ($stable(wiper_r) && $stable(ctrl_r)))
    else $error("aborted frame changed registers");

  a_busy_refuse_all: assert property (
    (busy_r && exec_w) |=> ($stable(wiper_r) && $stable(ctrl_r[2:0])))
    else $error("command accepted while busy");

  a_flag_after_store: assert property (
    $rose(ctrl_r.store_success_flag) |-> $past(busy_r))
    else $error("success flag rose without a store");

  a_blank_midscale: assert property (
    (state_r == ST_RESTORE && fill_blank) |=> (wiper_r == `RHEO_MIDSCALE) && idle_w)
    else $error("blank restore not midscale");

  a_readback_arm: assert property (
    (idle_w && exec_w && (cmd_w == `RHEO_CMD_RD_WIPER))
    |=> (rb_en_r && (rb_word_r[9:0] == $past(wiper_r))))
    else $error("wiper readback not armed");
endmodule : rheostat_serial_command_logic

// file: testbench/rheo_host_model.sv
// Host side SPI master model for the rheostat serial link.
// Assumes an open-drain readback pin with a pull-up on the board.
`timescale 1ns/1ps
module rheo_host_model (
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic sdo_pin
);
  // Link idles with the clock parked low
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // Shift n bits of w, sampling the pin on falling edges
  task automatic send_frame(input logic [31:0] w, input int n, output logic [31:0] rd);
    rd = 32'hFFFF_FFFF;
    sync_n = 1'b0;
    din = w[n-1];
    #7.5;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      #7.5;
      rd[i] = sdo_pin;
      sclk = 1'b0;
      // Late data change avoids racing the sample
      #3.0;
      din = (i > 0) ? w[i-1] : ~w[0];
      #4.5;
    end
    sync_n = 1'b1;
  endtask : send_frame
endmodule : rheo_host_model

// file: testbench/tb_rheostat_serial_command_logic.sv
// Self-checking bench for the rheostat serial command logic.
// Assumes the host model drives the link and a pull-up on readback.
`timescale 1ns/1ps
`include "rheo_defs.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_rheostat_serial_command_logic
  import rheo_pkg::*;
;
  // Short store time keeps the run brief
  localparam int STORE_CYC = 60;
  logic clk;
  logic rst_n;
  logic sclk;
  logic sync_n;
  logic din;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic [9:0] wiper_position;
  logic tolerance_cal_disable;
  logic store_success_flag;
  logic otp_busy;
  wire sdo_pin;
  int fail_count;
  int cmp_count;
  // Reference model state
  int m_wiper;
  int m_ctrl;
  int m_busy;
  int m_pend;
  int fuses[$];
  logic [15:0] rb_exp;
  logic [31:0] rd;
  logic [9:0] r;

  // Pull-up wins unless the device pulls low
  assign sdo_pin = serial_data_out_oe ? serial_data_out : 1'b1;

  rheostat_serial_command_logic #(.STORE_CYCLES(STORE_CYC), .COARSE(1'b0)) dut (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe),
    .wiper_position(wiper_position),
    .tolerance_cal_disable(tolerance_cal_disable),
    .store_success_flag(store_success_flag),
    .otp_busy(otp_busy)
  );

  rheo_host_model host (
    .sclk(sclk),
    .sync_n(sync_n),
    .din(din),
    .sdo_pin(sdo_pin)
  );

  // System clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Every visible result against the model
  task automatic check_state();
    `CHK(wiper_position, 10'(m_wiper))
    `CHK(tolerance_cal_disable, m_ctrl[2])
    `CHK(store_success_flag, m_ctrl[3])
    `CHK(otp_busy, m_busy[0])
    `CHK(serial_data_out_oe, 1'b0)
  endtask : check_state

  task automatic model_reset();
    m_wiper = (fuses.size() > 0) ? fuses[$] : `RHEO_MIDSCALE;
    m_ctrl = 0;
    m_busy = 0;
    rb_exp = 16'hFFFF;
  endtask : model_reset

  task automatic model_exec(input logic [3:0] cmd, input logic [9:0] d);
    if (m_busy == 0) begin
      case (cmd)
        `RHEO_CMD_WIPER: if (m_ctrl[1]) m_wiper = d;
        `RHEO_CMD_RD_WIPER: rb_exp = 16'(m_wiper);
        `RHEO_CMD_STORE: begin
          m_ctrl = m_ctrl & 7;
          m_busy = m_ctrl[0];
          m_pend = m_wiper;
        end
        `RHEO_CMD_RESTORE: m_wiper = (fuses.size() > 0) ? fuses[$] : `RHEO_MIDSCALE;
        `RHEO_CMD_RD_ADDR: rb_exp = 16'(fuses.size());
        `RHEO_CMD_CTRL: m_ctrl = (m_ctrl & 8) | (d & 7);
        `RHEO_CMD_RD_CTRL: rb_exp = 16'(m_ctrl);
        default: ;
      endcase
    end
  endtask : model_exec

  // One link transfer, then readback and state compares
  task automatic xfer(input logic [31:0] w, input int n, input logic [3:0] cmd,
                      input logic [9:0] d);
    host.send_frame(w, n, rd);
    `CHK(rd[15:0], rb_exp)
    rb_exp = 16'hFFFF;
    wait_clk(12);
    if (n % 16 == 0) model_exec(cmd, d);
    check_state();
  endtask : xfer

  task automatic frame(input logic [3:0] cmd, input logic [9:0] d);
    xfer({16'h0000, 2'b00, cmd, d}, 16, cmd, d);
  endtask : frame

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    wait_clk(5);
    rst_n = 1'b1;
    wait_clk(8);
    model_reset();
    check_state();
  endtask : do_reset

  // Main sequence
  initial begin
    rst_n = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'h0000_c837));
    do_reset();
    frame(`RHEO_CMD_WIPER, 10'($urandom));
    frame(`RHEO_CMD_RD_CTRL, 10'h000);
    frame(`RHEO_CMD_NOP, 10'($urandom));
    frame(`RHEO_CMD_CTRL, 10'h006);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
      frame(`RHEO_CMD_WIPER, r);
      frame(`RHEO_CMD_RD_WIPER, ~r);
    end
    frame(`RHEO_CMD_NOP, 10'h000);
    xfer(32'h0000_0015, 10, `RHEO_CMD_NOP, 10'h000);
    r = 10'($urandom);
    xfer({2'b00, `RHEO_CMD_WIPER, 10'h155, 2'b00, `RHEO_CMD_WIPER, r}, 32, `RHEO_CMD_WIPER, r);
    frame(`RHEO_CMD_STORE, 10'h000);
    frame(`RHEO_CMD_CTRL, 10'h003);
    frame(`RHEO_CMD_STORE, 10'($urandom));
    frame(`RHEO_CMD_WIPER, ~r);
    for (int i = 0; i < 200 && otp_busy !== 1'b0; i++) wait_clk(1);
    m_busy = 0;
    fuses.push_back(m_pend);
    m_ctrl = m_ctrl | 8;
    check_state();
    frame(`RHEO_CMD_RD_ADDR, 10'h000);
    frame(`RHEO_CMD_RD_CTRL, 10'h000);
    frame(`RHEO_CMD_WIPER, 10'($urandom));
    // Refresh from the stored word
    frame(`RHEO_CMD_RESTORE, 10'h000);
    frame(`RHEO_CMD_WIPER, 10'($urandom));
    do_reset();
    frame(`RHEO_CMD_WIPER, 10'($urandom));
    end_of_test();
  end

  // Cut a hang short well past the expected run
  initial begin
    #200_000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_rheostat_serial_command_logic
